//--- rtl/ppf_pkg.sv
package ppf_pkg;
  // ---------------------------------------------------------------
  // timing, clock is 25 MHz
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CUT_TIME_US = 59000;
  localparam int unsigned LIM_STEP_NS = 1700000;
  localparam int unsigned START_TIME_US = 60000;
  localparam int unsigned AVG_TIME_MS = 1000;
  localparam int unsigned CUT_CYCLES = CUT_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned LIM_STEP_CYCLES = LIM_STEP_NS / (1000000000 / CLK_HZ);
  localparam int unsigned START_CYCLES = START_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned AVG_CYCLES = AVG_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DOWN_RATIO = 16;

  // ---------------------------------------------------------------
  // register map (word offsets as byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_POLICE = 8'h08;
  localparam logic [7:0] REG_CLASS = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_FAULT = 8'h14;
  localparam logic [7:0] REG_CAP = 8'h18;

  // ctrl fields
  localparam int CTRL_ON0 = 0;
  localparam int CTRL_ON1 = 1;
  localparam int CTRL_AUTO = 2;
  localparam int CTRL_DUAL = 3;
  localparam int CTRL_SCF = 4;
  localparam int CTRL_POLEN = 5;
  localparam int CTRL_LIMT_LSB = 8;

  // inrush limit codes and register reset values
  localparam logic [7:0] INRUSH_LOW_CODE = 8'h08;
  localparam logic [7:0] INRUSH_HIGH_CODE = 8'h80;
  localparam logic [7:0] LIMIT_RESET = 8'h80;
  localparam logic [8:0] POLICE_RESET = 9'h100;

  // strap power capability table read back in REG_CAP, 0.1 W units
  localparam logic [9:0] SS_PWR0 = 10'h190;
  localparam logic [9:0] SS_PWR1 = 10'h1fe;
  localparam logic [9:0] SS_PWR2 = 10'h26c;
  localparam logic [9:0] SS_PWR3 = 10'h2c9;
  localparam logic [9:0] DS_PWR0 = 10'h082;
  localparam logic [9:0] DS_PWR1 = 10'h0ff;
  localparam logic [9:0] DS_PWR3 = 10'h164;

  typedef enum logic [3:0] {
    PPF_OFF = 4'b0001,
    PPF_INRUSH = 4'b0010,
    PPF_ON = 4'b0100,
    PPF_FAULT = 4'b1000
  } ppf_chan_state_type;

  // channel current measurement from the sense front end
  typedef struct packed {
    logic [7:0] current;
    logic over_cut;
    logic over_lim;
  } ppf_sense_type;

  // classification result from the class engine
  typedef struct packed {
    logic valid;
    logic [2:0] events;
    logic [2:0] sig0;
    logic [2:0] sig1;
    logic [2:0] sig2;
    logic over_current;
  } ppf_class_type;

  typedef struct packed {
    logic [2:0] cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
  } ppf_unused_type;
endpackage

//--- rtl/ppf_port.sv
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppf_port #(
  parameter int unsigned START_COUNT = ppf_pkg::START_CYCLES,
  parameter int unsigned CUT_COUNT = ppf_pkg::CUT_CYCLES,
  parameter int unsigned LIM_STEP = ppf_pkg::LIM_STEP_CYCLES,
  parameter int unsigned AVG_COUNT = ppf_pkg::AVG_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // straps
  input wire logic power_cap_strap_low,
  input wire logic power_cap_strap_high,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog front end
  input wire ppf_pkg::ppf_sense_type sense0,
  input wire ppf_pkg::ppf_sense_type sense1,
  input wire logic [7:0] port_power,
  input wire ppf_pkg::ppf_class_type class_result,
  input wire logic device_valid,
  // gate drive and limit codes
  output logic [1:0] gate_enable,
  output logic [7:0] port_current_limit_code
);
  import ppf_pkg::*;

  initial begin
    if (START_COUNT < 1 || START_COUNT > 32'h00ffffff || CUT_COUNT < 16 || CUT_COUNT > 32'h00ffffff ||
        LIM_STEP < 1 || LIM_STEP > 32'h000fffff || AVG_COUNT < 2 || AVG_COUNT > 32'h03ffffff) begin
      $error("ppf_port: parameter out of range");
    end
  end

  localparam logic [23:0] START_N = START_COUNT[23:0];
  localparam logic [27:0] CUT_N = 28'(CUT_COUNT * DOWN_RATIO);
  localparam logic [23:0] LIM_N = LIM_STEP[23:0];
  localparam logic [25:0] AVG_N = AVG_COUNT[25:0];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] strap_sync0;
    logic [2:0] strap_sync1;
    logic [1:0] strap_fill;
    logic strap_taken;
    logic [1:0] cap;
    logic [1:0] cmd_on;
    logic auto_mode;
    logic dual;
    logic scf;
    logic pol_en;
    logic [3:0] lim_cfg;
    logic [7:0] oper_limit;
    logic [8:0] police;
    ppf_chan_state_type [1:0] st;
    logic [1:0][23:0] start_t;
    logic [1:0][27:0] cut_t;
    logic [1:0][23:0] lim_t;
    logic [1:0][3:0] lim_mult;
    logic [1:0] flt_start;
    logic [1:0] flt_cut;
    logic [1:0] flt_lim;
    logic class_bad;
    logic class_ok;
    logic cls_low;
    logic [25:0] avg_cnt;
    logic [35:0] avg_acc;
    logic [1:0] gate;
    logic [7:0] code;
    logic [31:0] rdata;
    logic ack;
  } ppf_state_type;

  ppf_state_type s;
  ppf_state_type next_s;

  // legal multi event sequence for the device configuration
  function automatic logic seq_legal(input logic dual, input ppf_class_type c);
    logic ok;
    ok = 1'b0;
    if (c.events == 3'd1) begin
      ok = 1'b1;
    end else if (c.sig0 != c.sig1) begin
      ok = 1'b0;
    end else if (dual) begin
      ok = (c.sig0 != 3'd0) && (c.sig0 <= 3'd4) && ((c.events < 3'd3) || (c.sig2 == 3'd0) ||
           (c.sig0 == 3'd4 && c.sig2 == 3'd3));
    end else begin
      ok = (c.events < 3'd3) || (c.sig0 == 3'd4 && (c.sig2 == 3'd4 || c.events >= 3'd4));
    end
    return ok;
  endfunction

  // max single signature power, 0.1 W units
  function automatic logic [9:0] cap_ss(input logic [1:0] c);
    case (c)
      2'b00: return SS_PWR0;
      2'b01: return SS_PWR1;
      2'b10: return SS_PWR2;
      default: return SS_PWR3;
    endcase
  endfunction

  function automatic logic [9:0] cap_ds(input logic [1:0] c);
    case (c)
      2'b00: return DS_PWR0;
      2'b11: return DS_PWR3;
      default: return DS_PWR1;
    endcase
  endfunction

  logic [31:0] rd_mux;
  logic [1:0] kill;
  logic [1:0] start_fail;
  logic low_inrush;
  logic [1:0] want;
  logic [35:0] avg_thresh;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    kill = 2'b00;
    start_fail = 2'b00;
    rd_mux = 32'h0000_0000;
    // strap pins come from outside: three stages, taken when 2nd and 3rd agree
    next_s.strap_sync0 = {s.strap_sync0[1:0], power_cap_strap_low};
    next_s.strap_sync1 = {s.strap_sync1[1:0], power_cap_strap_high};
    // reset clears the stages, so wait for three real samples first
    if (s.strap_fill != 2'd3) begin
      next_s.strap_fill = s.strap_fill + 2'd1;
    end
    if (!s.strap_taken && s.strap_fill == 2'd3 && s.strap_sync0[2] == s.strap_sync0[1] &&
        s.strap_sync1[2] == s.strap_sync1[1]) begin
      next_s.cap = {s.strap_sync1[2], s.strap_sync0[2]};
      next_s.strap_taken = 1'b1;
    end
    // classification check, latched per result
    if (class_result.valid) begin
      next_s.class_bad = class_result.over_current || !seq_legal(s.dual, class_result);
      next_s.class_ok = !(class_result.over_current || !seq_legal(s.dual, class_result));
      // up to three events means an assigned class of 4 or less
      next_s.cls_low = class_result.events <= 3'd3;
    end
    // auto mode needs no command, only a good detection and class
    want = s.auto_mode ? {2{device_valid && s.class_ok}} : s.cmd_on;
    // 4P single signature class 0..4 uses low inrush; the class pulse is long gone here
    low_inrush = !s.dual && want == 2'b11 && s.class_ok && s.cls_low;
    // per channel sequencing
    for (int i = 0; i < 2; i++) begin
      ppf_sense_type se;
      se = (i == 0) ? sense0 : sense1;
      case (s.st[i])
        PPF_OFF: begin
          if (want[i]) begin
            next_s.st[i] = PPF_INRUSH;
            next_s.start_t[i] = 24'h00_0000;
          end
        end
        PPF_INRUSH: begin
          next_s.start_t[i] = s.start_t[i] + 24'h00_0001;
          if (s.start_t[i] == START_N - 24'h00_0001) begin
            if (se.over_lim) begin
              start_fail[i] = 1'b1;
            end else begin
              next_s.st[i] = PPF_ON;
              next_s.cut_t[i] = 28'h000_0000;
              next_s.lim_t[i] = 24'h00_0000;
              next_s.lim_mult[i] = 4'h0;
            end
          end
        end
        PPF_ON: begin
          // cut timer: up by 16 over threshold, down by 1 below
          if (se.over_cut || (s.lim_cfg == 4'h0 && se.over_lim)) begin
            next_s.cut_t[i] = s.cut_t[i] + 28'(DOWN_RATIO);
          end else if (s.cut_t[i] != 28'h000_0000) begin
            next_s.cut_t[i] = s.cut_t[i] - 28'h000_0001;
          end
          if (s.cut_t[i] >= CUT_N - 28'(DOWN_RATIO)) begin
            if (se.over_cut || (s.lim_cfg == 4'h0 && se.over_lim)) begin
              kill[i] = 1'b1;
              next_s.flt_cut[i] = 1'b1;
            end
          end
          // limit timer, steps of the 1.7 ms unit
          if (s.lim_cfg != 4'h0 && se.over_lim) begin
            if (s.lim_t[i] == LIM_N - 24'h00_0001) begin
              next_s.lim_t[i] = 24'h00_0000;
              next_s.lim_mult[i] = s.lim_mult[i] + 4'h1;
              if (s.lim_mult[i] + 4'h1 >= s.lim_cfg) begin
                kill[i] = 1'b1;
                next_s.flt_lim[i] = 1'b1;
              end
            end else begin
              next_s.lim_t[i] = s.lim_t[i] + 24'h00_0001;
            end
          end else begin
            next_s.lim_t[i] = 24'h00_0000;
            next_s.lim_mult[i] = 4'h0;
          end
        end
        PPF_FAULT: begin
          if (!want[i]) begin
            next_s.st[i] = PPF_OFF;
          end
        end
        default: next_s.st[i] = PPF_OFF;
      endcase
      if (!want[i] && s.st[i] != PPF_FAULT) begin
        next_s.st[i] = PPF_OFF;
      end
    end
    // failed inrush drops every channel in inrush
    if (start_fail != 2'b00) begin
      for (int i = 0; i < 2; i++) begin
        if (s.st[i] == PPF_INRUSH) begin
          next_s.st[i] = PPF_FAULT;
          next_s.flt_start[i] = 1'b1;
        end
      end
    end
    // one second fixed window of port power, cleared at the end of each window
    // power and threshold share 0.5 W units; the window sum includes this cycle
    avg_thresh = 36'(s.police) * 36'(AVG_COUNT);
    if (s.st[0] == PPF_ON || s.st[1] == PPF_ON) begin
      next_s.avg_acc = s.avg_acc + 36'(port_power);
      if (s.avg_cnt == AVG_N - 26'h000_0001) begin
        next_s.avg_cnt = 26'h000_0000;
        next_s.avg_acc = 36'h0_0000_0000;
        if (s.pol_en && s.avg_acc + 36'(port_power) > avg_thresh) begin
          kill = 2'b11;
          next_s.flt_cut = s.flt_cut | {s.st[1] == PPF_ON, s.st[0] == PPF_ON};
        end
      end else begin
        next_s.avg_cnt = s.avg_cnt + 26'h000_0001;
      end
    end else begin
      next_s.avg_cnt = 26'h000_0000;
      next_s.avg_acc = 36'h0_0000_0000;
    end
    // fault scope: single signature without option kills the port
    if (kill != 2'b00) begin
      for (int i = 0; i < 2; i++) begin
        if ((kill[i] || (!s.dual && !s.scf) || kill == 2'b11) && s.st[i] != PPF_OFF) begin
          next_s.st[i] = PPF_FAULT;
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      next_s.gate[i] = next_s.st[i] == PPF_INRUSH || next_s.st[i] == PPF_ON;
    end
    // inrush code until inrush done, then the programmed limit
    if (next_s.st[0] == PPF_INRUSH || next_s.st[1] == PPF_INRUSH) begin
      next_s.code = low_inrush ? INRUSH_LOW_CODE : INRUSH_HIGH_CODE;
    end else begin
      next_s.code = s.oper_limit;
    end
    // register bus
    case (wb_adr_i)
      REG_CTRL: rd_mux = {20'h0_0000, s.lim_cfg, 2'b00, s.pol_en, s.scf, s.dual, s.auto_mode, s.cmd_on};
      REG_LIMIT: rd_mux = {24'h00_0000, s.oper_limit};
      REG_POLICE: rd_mux = {23'h00_0000, s.police};
      REG_CLASS: rd_mux = {30'h0000_0000, s.class_ok, s.class_bad};
      REG_STATUS: rd_mux = {24'h00_0000, s.st[1], s.st[0]};
      REG_FAULT: rd_mux = {26'h000_0000, s.flt_lim, s.flt_cut, s.flt_start};
      REG_CAP: rd_mux = {10'h000, cap_ds(s.cap), cap_ss(s.cap), s.cap};
      default: rd_mux = 32'h0000_0000;
    endcase
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.rdata = rd_mux;
    if (wb_cyc_i && wb_stb_i && !s.ack && wb_we_i) begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        next_s.cmd_on = wb_dat_i[CTRL_ON1:CTRL_ON0];
        next_s.auto_mode = wb_dat_i[CTRL_AUTO];
        next_s.dual = wb_dat_i[CTRL_DUAL];
        next_s.scf = wb_dat_i[CTRL_SCF];
        next_s.pol_en = wb_dat_i[CTRL_POLEN];
      end
      if (wb_adr_i == REG_CTRL && wb_sel_i[1]) begin
        next_s.lim_cfg = wb_dat_i[CTRL_LIMT_LSB +: 4];
      end
      if (wb_adr_i == REG_LIMIT && wb_sel_i[0]) begin
        next_s.oper_limit = wb_dat_i[7:0];
      end
      if (wb_adr_i == REG_POLICE && wb_sel_i[0]) begin
        next_s.police[7:0] = wb_dat_i[7:0];
      end
      if (wb_adr_i == REG_POLICE && wb_sel_i[1]) begin
        next_s.police[8] = wb_dat_i[8];
      end
      // write one to clear; a fault set this cycle wins
      if (wb_adr_i == REG_FAULT && wb_sel_i[0]) begin
        next_s.flt_start = next_s.flt_start & ~(wb_dat_i[1:0] & ~(s.flt_start ^ next_s.flt_start));
        next_s.flt_cut = next_s.flt_cut & ~(wb_dat_i[3:2] & ~(s.flt_cut ^ next_s.flt_cut));
        next_s.flt_lim = next_s.flt_lim & ~(wb_dat_i[5:4] & ~(s.flt_lim ^ next_s.flt_lim));
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '0;
      s.st[0] <= PPF_OFF;
      s.st[1] <= PPF_OFF;
      s.oper_limit <= LIMIT_RESET;
      s.police <= POLICE_RESET;
    end else if (clock_en) begin
      s <= next_s;
    end
  end

  assign gate_enable = s.gate;
  assign port_current_limit_code = s.code;
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence inrush_seen(int i);
    s.st[i] == PPF_INRUSH;
  endsequence

  AST_INRUSH_CODE: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && next_s.st[0] == PPF_INRUSH |=> s.code == INRUSH_LOW_CODE || s.code == INRUSH_HIGH_CODE)
    else $error("inrush code wrong");
  AST_OPER_CODE: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && next_s.st == {PPF_ON, PPF_ON} |=> s.code == $past(s.oper_limit))
    else $error("operating limit not applied");
  AST_START_FAIL: assert property (@(posedge clock) disable iff (!reset_n)
    ((clock_en && start_fail[0]) and inrush_seen(0)) |=> s.flt_start[0] && s.st[0] == PPF_FAULT)
    else $error("inrush failure not handled");
  AST_CUT_KILL: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && s.st[0] == PPF_ON && kill[0] |=> s.st[0] == PPF_FAULT && !s.gate[0])
    else $error("cut expiry did not turn off");
  AST_PORT_SCOPE: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && kill[0] && !s.dual && !s.scf && s.st[1] == PPF_ON |=> s.st[1] == PPF_FAULT)
    else $error("port not turned off");
  AST_LIM_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && s.lim_cfg == 4'h0 |=> (s.flt_lim & ~$past(s.flt_lim)) == 2'b00)
    else $error("limit timer ran while disabled");
  AST_CUT_DECAY: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && s.st[0] == PPF_ON && !sense0.over_cut && !sense0.over_lim && s.cut_t[0] != 0
    |=> s.cut_t[0] == $past(s.cut_t[0]) - 1)
    else $error("cut timer decay wrong");
  AST_GATE_CMD: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && !s.auto_mode && !s.cmd_on[1] |=> !s.gate[1])
    else $error("uncommanded channel powered");
endmodule
`default_nettype wire

//--- sim/ppf_pd_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// powered device on two pairsets
// ---------------------------------------------------------------
module ppf_pd_model (
  // channel gates from the port
  input wire logic [1:0] gate_enable,
  // load set by the bench
  input wire logic [7:0] load_current,
  input wire logic [1:0] cut_flag,
  input wire logic [1:0] lim_flag,
  input wire logic [7:0] load_power,
  // sense front end toward the port
  output ppf_pkg::ppf_sense_type sense0,
  output ppf_pkg::ppf_sense_type sense1,
  output logic [7:0] port_power
);
  import ppf_pkg::*;
  // an unpowered pairset draws nothing, so no stale load leaks through
  always_comb begin
    sense0 = '{gate_enable[0] ? load_current : 8'h00, gate_enable[0] & cut_flag[0], gate_enable[0] & lim_flag[0]};
    sense1 = '{gate_enable[1] ? load_current : 8'h00, gate_enable[1] & cut_flag[1], gate_enable[1] & lim_flag[1]};
    port_power = (|gate_enable) ? load_power : 8'h00;
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ppf_pkg::*;
  logic clock = 0, reset_n = 0, strap_lo = 0, strap_hi = 0, device_valid = 0, clk_en = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 0, code, ld = 8'h04, pwr = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [1:0] gate_enable, oc = 0, ol = 0;
  ppf_sense_type sense0, sense1;
  logic [7:0] port_power;
  ppf_class_type class_result = '0;
  logic [9:0] ss_tab [4] = '{SS_PWR0, SS_PWR1, SS_PWR2, SS_PWR3};
  logic [9:0] ds_tab [4] = '{DS_PWR0, DS_PWR1, DS_PWR1, DS_PWR3};
  int miscompares = 0, checks_done = 0, cycles = 0;
  // short counts keep the run brief
  ppf_port #(.START_COUNT(20), .CUT_COUNT(64), .LIM_STEP(8), .AVG_COUNT(32)) ppf_port_inst (
    .clock(clock), .reset_n(reset_n), .clock_en(clk_en),
    .power_cap_strap_low(strap_lo), .power_cap_strap_high(strap_hi),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sense0(sense0), .sense1(sense1), .port_power(port_power), .class_result(class_result),
    .device_valid(device_valid), .gate_enable(gate_enable), .port_current_limit_code(code));
  ppf_pd_model ppf_pd_model_inst (.gate_enable(gate_enable), .load_current(ld), .cut_flag(oc),
    .lim_flag(ol), .load_power(pwr), .sense0(sense0), .sense1(sense1), .port_power(port_power));
  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end
  // far above the thousand or so cycles the tests need
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one classic cycle; ack is waited for, never assumed
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock);
  endtask
  task automatic do_reset;
    reset_n <= 0;
    oc <= 0;
    ol <= 0;
    tick(8);
    reset_n <= 1;
    tick(4);
  endtask
  task automatic cls(input logic [2:0] ev, s0, s1, s2, input logic ov);
    class_result <= '{1'b1, ev, s0, s1, s2, ov};
    @(posedge clock);
    class_result <= '0;
    tick(3);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      {strap_hi, strap_lo} <= i[1:0];
      do_reset;
      wb(REG_CAP, 0, 0);
      check(q[21:0], {ds_tab[i], ss_tab[i], i[1:0]});
    end
    {strap_hi, strap_lo} <= 2'b00;
    tick(6);
    wb(REG_CAP, 0, 0);
    check(q[1:0], 2'b11);
    wb(8'h40, 1, 32'hffff);
    wb(8'h40, 0, 0);
    check(q, 0);
    wb(REG_POLICE, 0, 0);
    check(q, 32'h100);
    wb(REG_LIMIT, 1, 32'h55);
    wb(REG_CTRL, 1, 32'h1);
    tick(2);
    check(gate_enable, 2'b01);
    check(code, 8'h80);
    wb(REG_STATUS, 0, 0);
    check(q[7:0], {PPF_OFF, PPF_INRUSH});
    // a low clock enable freezes the inrush timer
    clk_en <= 0;
    tick(30);
    clk_en <= 1;
    wb(REG_STATUS, 0, 0);
    check(q[7:0], {PPF_OFF, PPF_INRUSH});
    tick(30);
    wb(REG_STATUS, 0, 0);
    check(q[7:0], {PPF_OFF, PPF_ON});
    check(code, 8'h55);
    // classification, then a four-pair class 3 device that overdraws in inrush
    do_reset;
    cls(3'd1, 3'd3, 3'd0, 3'd0, 1'b1);
    wb(REG_CLASS, 0, 0);
    check(q[0], 1'b1);
    cls(3'd2, 3'd4, 3'd2, 3'd0, 1'b0);
    wb(REG_CLASS, 0, 0);
    check(q[0], 1'b1);
    cls(3'd1, 3'd3, 3'd0, 3'd0, 1'b0);
    wb(REG_CLASS, 0, 0);
    check(q[0], 1'b0);
    ld <= 8'hff;
    ol <= 2'b11;
    wb(REG_CTRL, 1, 32'h3);
    tick(2);
    check(gate_enable, 2'b11);
    check(code, 8'h08);
    tick(30);
    check(gate_enable, 2'b00);
    wb(REG_FAULT, 0, 0);
    check(q[1:0], 2'b11);
    ld <= 8'h04;
    ol <= 2'b00;
    wb(REG_CTRL, 1, 32'h0);
    wb(REG_FAULT, 1, 32'h3f);
    wb(REG_FAULT, 0, 0);
    check(q[5:0], 6'h00);
    // cut timer decays slowly, then expires; port or channel by option
    for (int s = 0; s < 2; s++) begin
      do_reset;
      wb(REG_LIMIT, 1, 32'h55);
      wb(REG_CTRL, 1, 32'h3 | (s << 4));
      tick(30);
      oc <= 2'b01;
      tick(40);
      oc <= 2'b00;
      tick(32);
      oc <= 2'b01;
      tick(20);
      check(gate_enable, 2'b11);
      check(code, 8'h55);
      tick(12);
      oc <= 2'b00;
      check(gate_enable, s ? 2'b10 : 2'b00);
      wb(REG_FAULT, 0, 0);
      check(q[2], 1'b1);
    end
    // limit timer with field 2, then field 0 tracked by the cut timer
    for (int c = 2; c >= 0; c -= 2) begin
      do_reset;
      wb(REG_CTRL, 1, (c << 8) | 32'hb);
      tick(30);
      ol <= 2'b10;
      tick(12);
      check(gate_enable, 2'b11);
      tick(c ? 10 : 70);
      ol <= 2'b00;
      check(gate_enable, 2'b01);
      wb(REG_FAULT, 0, 0);
      check(q[c ? 5 : 3], 1'b1);
    end
    // averaged power policing
    do_reset;
    wb(REG_POLICE, 1, 32'h14);
    wb(REG_POLICE, 0, 0);
    check(q, 32'h14);
    wb(REG_CTRL, 1, 32'h33);
    // equal to the threshold is not above it
    pwr <= 8'd20;
    tick(130);
    check(gate_enable, 2'b11);
    pwr <= 8'd21;
    tick(100);
    check(gate_enable, 2'b00);
    wb(REG_FAULT, 0, 0);
    check(q[3:2], 2'b11);
    pwr <= 8'd0;
    // auto mode powers a valid device unaided
    do_reset;
    device_valid <= 1;
    wb(REG_CTRL, 1, 32'h4);
    cls(3'd1, 3'd3, 3'd0, 3'd0, 1'b0);
    for (int n = 0; n < 200 && gate_enable === 2'b00; n++) @(posedge clock);
    check(gate_enable === 2'b00, 1'b0);
    close_out;
  end
endmodule
`default_nettype wire
